//--- ecm_pkg.sv
// Package of offsets, field positions and reset values for the EC misc register bank.
`default_nettype none
package ecm_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ECM_ADDR_W = 8;
    localparam int ECM_DATA_W = 32;
    localparam logic [7:0] ECM_OFS_FAULT = 8'h14;
    localparam logic [7:0] ECM_OFS_VECTOR = 8'h18;
    localparam logic [7:0] ECM_OFS_TRACE = 8'h1C;
    localparam int ECM_CTL_BIT = 0;
    localparam logic ECM_RST_FAULT = 1'h0;
    localparam logic ECM_RST_VECTOR = 1'h1;
    localparam logic ECM_RST_TRACE = 1'h0;
    localparam logic [31:0] ECM_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

//--- ecm_ctl_bit.sv
// One read-write control bit with a constant reset value.
`default_nettype none
module ecm_ctl_bit #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Write strobe and data.
    input wire logic i_write,
    input wire logic i_data,
    // Stored value.
    output logic o_value
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // The bit loads on its write strobe and returns to its default on reset.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_value <= RESET_VALUE;
        end
        else if (i_write)
        begin
            o_value <= i_data;
        end
    end
endmodule
`default_nettype wire

//--- ecm_reg_bank.sv
// Miscellaneous EC control register bank with memory fault, vector and trace controls.
`default_nettype none
module ecm_reg_bank (
    // Host clock and main-well reset.
    input wire logic i_clock,
    input wire logic i_rst,
    // Sleep request from the power and clock controller.
    input wire logic i_sleep_req,
    // Register interface from the EC core.
    input wire logic i_sel,
    input wire logic i_write,
    input wire logic [ecm_pkg::ECM_ADDR_W-1:0] i_addr,
    input wire logic [ecm_pkg::ECM_DATA_W-1:0] i_wdata,
    output logic [ecm_pkg::ECM_DATA_W-1:0] o_rdata,
    output logic o_ready,
    // Control outputs.
    output logic o_mem_fault_suppress,
    output logic o_direct_vector_select,
    output logic o_trace_pin_force,
    output logic o_irq
);
    import ecm_pkg::*;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Sleep does not gate the decode, so access continues while asleep.
    wire logic hit_fault = (i_addr == ECM_OFS_FAULT);
    wire logic hit_vector = (i_addr == ECM_OFS_VECTOR);
    wire logic hit_trace = (i_addr == ECM_OFS_TRACE);
    wire logic wr = i_sel & i_write;
    wire logic rd = i_sel & ~i_write;
    wire logic wr_fault = wr & hit_fault;
    wire logic wr_vector = wr & hit_vector;
    wire logic wr_trace = wr & hit_trace;
    wire logic wbit = i_wdata[ECM_CTL_BIT];

    // Ready is always given: every access completes in one host clock.
    assign o_ready = 1'b1;
    // The bank has no interrupt source.
    assign o_irq = 1'b0;

    // ----------------------------------------------------------------
    // Control bits
    // ----------------------------------------------------------------
    ecm_ctl_bit #(.RESET_VALUE(ECM_RST_FAULT)) u_fault (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_fault),
        .i_data(wbit),
        .o_value(o_mem_fault_suppress)
    );
    ecm_ctl_bit #(.RESET_VALUE(ECM_RST_VECTOR)) u_vector (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_vector),
        .i_data(wbit),
        .o_value(o_direct_vector_select)
    );
    ecm_ctl_bit #(.RESET_VALUE(ECM_RST_TRACE)) u_trace (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_write(wr_trace),
        .i_data(wbit),
        .o_value(o_trace_pin_force)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read data is registered; reserved bits and offsets return zero.
    logic [ECM_DATA_W-1:0] rdata_nxt;
    always_comb
    begin
        rdata_nxt = ECM_ZERO;
        if (hit_fault)
        begin
            rdata_nxt[ECM_CTL_BIT] = o_mem_fault_suppress;
        end
        else if (hit_vector)
        begin
            rdata_nxt[ECM_CTL_BIT] = o_direct_vector_select;
        end
        else if (hit_trace)
        begin
            rdata_nxt[ECM_CTL_BIT] = o_trace_pin_force;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= ECM_ZERO;
        end
        else if (rd)
        begin
            o_rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // The interrupt output must never rise, whatever the bus does.
    property p_no_irq;
        @(posedge i_clock) disable iff (i_rst) !o_irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq raised");

    // Ready must stand high, asleep or awake, so no access ever stalls.
    property p_ready_high;
        @(posedge i_clock) disable iff (i_rst) o_ready;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready low");

    // On the first edge after reset the three control bits and the read data must show their defaults.
    property p_reset_defaults;
        @(posedge i_clock)
            $fell(i_rst) |-> (o_mem_fault_suppress == ECM_RST_FAULT)
                && (o_direct_vector_select == ECM_RST_VECTOR)
                && (o_trace_pin_force == ECM_RST_TRACE) && (o_rdata == ECM_ZERO);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("reset value wrong");

    // A write while asleep must still land in the trace bit.
    property p_sleep_access;
        @(posedge i_clock) disable iff (i_rst)
            (i_sleep_req && wr_trace) |=> (o_trace_pin_force == $past(wbit));
    endproperty
    a_sleep_access: assert property (p_sleep_access) else $error("write lost asleep");

    // A read while asleep must still return the stored trace bit.
    property p_sleep_read;
        @(posedge i_clock) disable iff (i_rst)
            (i_sleep_req && rd && hit_trace)
                |=> o_rdata[ECM_CTL_BIT] == $past(o_trace_pin_force);
    endproperty
    a_sleep_read: assert property (p_sleep_read) else $error("read lost asleep");

    // ----------------------------------------------------------------
    // Write checks
    // ----------------------------------------------------------------
    // A write to the fault offset loads the control bit on the next cycle.
    property p_fault_write;
        @(posedge i_clock) disable iff (i_rst) wr_fault |=> o_mem_fault_suppress == $past(wbit);
    endproperty
    a_fault_write: assert property (p_fault_write) else $error("fault bit wrong");

    // Without its own write strobe the fault bit must hold.
    property p_fault_hold;
        @(posedge i_clock) disable iff (i_rst) !wr_fault |=> $stable(o_mem_fault_suppress);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault bit moved");

    // A write to the vector offset loads the control bit on the next cycle.
    property p_vector_write;
        @(posedge i_clock) disable iff (i_rst)
            wr_vector |=> o_direct_vector_select == $past(wbit);
    endproperty
    a_vector_write: assert property (p_vector_write) else $error("vector bit wrong");

    // Without its own write strobe the vector bit must hold.
    property p_vector_hold;
        @(posedge i_clock) disable iff (i_rst) !wr_vector |=> $stable(o_direct_vector_select);
    endproperty
    a_vector_hold: assert property (p_vector_hold) else $error("vector bit moved");

    // A write to the trace offset loads the control bit on the next cycle.
    property p_trace_write;
        @(posedge i_clock) disable iff (i_rst) wr_trace |=> o_trace_pin_force == $past(wbit);
    endproperty
    a_trace_write: assert property (p_trace_write) else $error("trace bit wrong");

    // Without its own write strobe the trace bit must hold.
    property p_trace_hold;
        @(posedge i_clock) disable iff (i_rst) !wr_trace |=> $stable(o_trace_pin_force);
    endproperty
    a_trace_hold: assert property (p_trace_hold) else $error("trace bit moved");

    // A write of any offset must leave the read data as they were.
    property p_rdata_hold;
        @(posedge i_clock) disable iff (i_rst) wr |=> $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("write moved read data");

    // ----------------------------------------------------------------
    // Read checks
    // ----------------------------------------------------------------
    // A read of the fault offset returns the stored bit one cycle later.
    property p_read_fault;
        @(posedge i_clock) disable iff (i_rst)
            (rd && hit_fault) |=> o_rdata[ECM_CTL_BIT] == $past(o_mem_fault_suppress);
    endproperty
    a_read_fault: assert property (p_read_fault) else $error("fault read mismatch");

    // A read of the vector offset returns the stored bit one cycle later.
    property p_read_vector;
        @(posedge i_clock) disable iff (i_rst)
            (rd && hit_vector) |=> o_rdata[ECM_CTL_BIT] == $past(o_direct_vector_select);
    endproperty
    a_read_vector: assert property (p_read_vector) else $error("read mismatch");

    // A read of the trace offset returns the stored bit one cycle later.
    property p_read_trace;
        @(posedge i_clock) disable iff (i_rst)
            (rd && hit_trace) |=> o_rdata[ECM_CTL_BIT] == $past(o_trace_pin_force);
    endproperty
    a_read_trace: assert property (p_read_trace) else $error("trace read mismatch");

    // Every bit above the control bit must read as zero.
    property p_reserved_zero;
        @(posedge i_clock) disable iff (i_rst)
            rd |=> (o_rdata >> (ECM_CTL_BIT + 1)) == ECM_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero");

    // A read of an unmapped offset must return an all-zero word.
    property p_unmapped_read;
        @(posedge i_clock) disable iff (i_rst)
            (i_sel && !i_write && !hit_fault && !hit_vector && !hit_trace) |=> o_rdata == ECM_ZERO;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped nonzero");
endmodule
`default_nettype wire

//--- ecm_core_model.sv
// Model of the EC core that drives the register interface of the bank.
`default_nettype none
module ecm_core_model (
    // Clock and read data.
    input wire logic i_clock,
    input wire logic [ecm_pkg::ECM_DATA_W-1:0] i_rdata,
    // Access request.
    output logic o_sel,
    output logic o_write,
    output logic [ecm_pkg::ECM_ADDR_W-1:0] o_addr,
    output logic [ecm_pkg::ECM_DATA_W-1:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecm_pkg::*;
    // Idle address and data lines carry the inverse of the last value, so stale data never looks valid.
    initial
    begin
        o_sel = 1'b0;
        o_write = 1'b0;
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
    end
    // One single-cycle access; read data is taken one edge after the request.
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_clock);
        #1;
        o_sel = 1'b1;
        o_write = w;
        o_addr = a;
        o_wdata = d;
        @(posedge i_clock);
        #1;
        q = i_rdata;
        o_sel = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- ecm_reg_bank_test.sv
// Self-checking testbench of the EC misc register bank.
`default_nettype none
module ecm_reg_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ecm_pkg::*;
    logic i_clock;
    logic i_rst = 1'b1;
    logic i_sleep_req = 1'b0;
    logic sel, wr, ready, flt, vec, trc, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] ofs [3] = '{ECM_OFS_FAULT, ECM_OFS_VECTOR, ECM_OFS_TRACE};
    logic [2:0] dflt = {ECM_RST_TRACE, ECM_RST_VECTOR, ECM_RST_FAULT};
    // Design and core model.
    ecm_reg_bank DUT (.i_clock(i_clock), .i_rst(i_rst), .i_sleep_req(i_sleep_req),
        .i_sel(sel), .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_ready(ready), .o_mem_fault_suppress(flt), .o_direct_vector_select(vec),
        .o_trace_pin_force(trc), .o_irq(irq));
    ecm_core_model M (.i_clock(i_clock), .i_rdata(rdata), .o_sel(sel), .o_write(wr),
        .o_addr(addr), .o_wdata(wdata));
    // Clock at 40 MHz.
    initial
    begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads the three registers back and checks the control outputs.
    task automatic check_all(input logic [2:0] e);
        for (int k = 0; k < 3; k++)
        begin
            M.access(1'b0, ofs[k], 32'h0000_0000, q);
            chk(q, {31'h0, e[k]});
        end
        chk({29'h0, trc, vec, flt}, {29'h0, e});
        chk({30'h0, irq, ready}, 32'h0000_0001);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            $display("BAD %0t timeout", $time);
            print_verdict();
        end
    end
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge i_clock);
        #1 i_rst = 1'b0;
        check_all(dflt);
        $display("test defaults done");
        for (int k = 0; k < 3; k++)
        begin
            for (int j = 0; j < 3; j++)
                M.access(1'b1, ofs[j], (j == k) ? 32'hFFFF_FFFF : 32'hFFFF_FFFE, q);
            check_all(3'h1 << k);
        end
        $display("test single bits done");
        i_sleep_req = 1'b1;
        for (int k = 0; k < 3; k++)
            M.access(1'b1, ofs[k], 32'hFFFF_FFFF, q);
        check_all(3'h7);
        M.access(1'b1, 8'h20, 32'h0000_0000, q);
        chk(q, 32'h0000_0001);
        M.access(1'b1, 8'h10, 32'h0000_0000, q);
        M.access(1'b0, 8'h20, 32'h0000_0000, q);
        chk(q, 32'h0000_0000);
        check_all(3'h7);
        $display("test sleep and unmapped done");
        i_rst = 1'b1;
        @(posedge i_clock);
        #1 i_rst = 1'b0;
        check_all(dflt);
        $display("test second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
